// [verilog/fts_pkg.sv]
// shared constants for the fractional transmit frame strobe block
package fts_pkg;
   // framing modes of the port
   typedef enum logic [1:0] {
      FTS_MODE_OFF,
      FTS_MODE_EXT_FRAC,
      FTS_MODE_FLEX_FRAC,
      FTS_MODE_FRAMED
   } fts_mode_t;

   // reference clock choices, index into the synchronised clock vector
   localparam logic [2:0] FTS_CLK_TX_IN = 3'h0;
   localparam logic [2:0] FTS_CLK_TX_LINE = 3'h1;
   localparam logic [2:0] FTS_CLK_TX_OUT = 3'h2;
   localparam logic [2:0] FTS_CLK_RX_OUT = 3'h3;
   localparam logic [2:0] FTS_CLK_RX_LINE = 3'h4;
   localparam int FTS_NUM_CLKS = 5;

   // register byte offsets
   localparam logic [3:0] FTS_REG_CTRL = 4'h0;
   localparam logic [3:0] FTS_REG_STATUS = 4'h4;
   localparam int FTS_ADDR_W = 4;

   // control field positions
   localparam int FTS_CTRL_MODE_LSB = 0;
   localparam int FTS_CTRL_PINS_EN = 2;
   localparam int FTS_CTRL_SOF_FN = 3;
   localparam int FTS_CTRL_FBE_FN = 4;
   localparam int FTS_CTRL_CSEL_LSB = 5;
   localparam int FTS_CTRL_CLK_INV = 8;
   localparam int FTS_CTRL_INV_SOF = 9;
   localparam int FTS_CTRL_INV_FBE = 10;
   localparam int FTS_CTRL_INV_PVAL = 11;
   localparam int FTS_CTRL_INV_PDAT = 12;
   localparam int FTS_CTRL_W = 13;
   localparam logic [FTS_CTRL_W-1:0] FTS_CTRL_RESET = 13'h0000;

   // status field positions
   localparam int FTS_STAT_POS_LSB = 0;
   localparam int FTS_STAT_POS_W = 13;
   localparam int FTS_STAT_UNDERRUN = 13;
   localparam int FTS_STAT_FIFO_EMPTY = 14;

   // strobes lead the bit they announce by this many reference clocks
   localparam int FTS_LEAD = 3;

   // frame shape defaults
   localparam int FTS_FRAME_BITS = 4760;
   localparam int FTS_OH_BITS = 8;
   localparam int FTS_WORD_W = 8;
   localparam int FTS_FIFO_DEPTH = 32;
endpackage : fts_pkg

// [verilog/fts_fifo.sv]
// payload word fifo with registered read data
`timescale 1ns/100ps
module fts_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
   logic [AW:0] count, next_count;
   logic out_valid, next_out_valid;
   logic [WIDTH-1:0] out_data, next_out_data;
   logic push, pop;

   always_comb begin
      push = in_valid_i && (count != DEPTH[AW:0]);
      // output stage reloads whenever it is empty or being taken
      pop = (count != '0) && (!out_valid || out_ready_i);
      next_wptr = push ? wptr + 1'b1 : wptr;
      next_rptr = pop ? rptr + 1'b1 : rptr;
      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      next_out_valid = out_valid;
      next_out_data = out_data;
      if (pop) begin
         next_out_valid = 1'b1;
         next_out_data = mem[rptr];
      end else if (out_ready_i) begin
         next_out_valid = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wptr] <= in_data_i;
      end
      if (rst_i) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
         in_ready_o <= 1'b0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
         in_ready_o <= (next_count != DEPTH[AW:0]);
      end
   end

   assign out_valid_o = out_valid;
   assign out_data_o = out_data;
endmodule : fts_fifo

// [verilog/fts_tx_strobes.sv]
// transmit frame strobes and payload serialiser with wishbone control
`timescale 1ns/100ps
// What this block does
// - In external or flexible fractional mode with pins enabled and the function chosen, a start-of-frame strobe is driven.
// - Start-of-frame and frame-bit enable also work in plain framed mode when pins and function are enabled.
// - Start-of-frame is one reference clock wide and comes three reference clocks before the first overhead bit.
// - Frame-bit enable, when chosen, marks which input bit positions carry payload.
// - Frame-bit enable rises three reference clocks before the first payload bit.
// - Frame-bit enable falls three reference clocks before the end of the payload bits.
// - Strobes change on the rising reference edge, or the falling one when the clock is inverted.
// - The reference clock defaults to the transmit clock input and may be any of five clock pins.
// - Each strobe output can be inverted on its own, apart from the edge choice.
// - In flexible fractional mode the payload valid output is high exactly while a payload bit is shown.
module fts_tx_strobes
   import fts_pkg::*;
#(
   parameter int FRAME_BITS = fts_pkg::FTS_FRAME_BITS,
   parameter int OH_BITS = fts_pkg::FTS_OH_BITS,
   parameter int WORD_W = fts_pkg::FTS_WORD_W,
   parameter int FIFO_DEPTH = fts_pkg::FTS_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [fts_pkg::FTS_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // reference clock pins
   input wire logic tx_clock_in_i,
   input wire logic tx_line_clock_i,
   input wire logic tx_clock_out_i,
   input wire logic rx_clock_out_i,
   input wire logic rx_line_clock_i,
   // payload words from the cell/packet processor
   input wire logic pay_valid_i,
   input wire logic [WORD_W-1:0] pay_data_i,
   output logic pay_ready_o,
   // strobe and payload pins
   output logic tx_frame_start_pulse_o,
   output logic tx_frame_bit_enable_o,
   output logic tx_payload_valid_out_o,
   output logic tx_payload_bit_out_o
);
   import fts_pkg::*;

   localparam int POS_W = FTS_STAT_POS_W;
   localparam int CNT_W = $clog2(WORD_W + 1);
   localparam logic [POS_W-1:0] POS_LAST = POS_W'(FRAME_BITS - 1);
   localparam logic [POS_W-1:0] POS_SOF = POS_W'(FRAME_BITS - FTS_LEAD);
   localparam logic [POS_W-1:0] POS_FBE_RISE = POS_W'(OH_BITS - FTS_LEAD);
   localparam logic [POS_W-1:0] POS_FBE_FALL = POS_W'(FRAME_BITS - FTS_LEAD);
   localparam logic [POS_W-1:0] POS_PAY = POS_W'(OH_BITS);

   // ---------------- wishbone registers ----------------
   logic [FTS_CTRL_W-1:0] ctrl, next_ctrl;
   logic underrun, next_underrun;
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic [POS_W-1:0] pos, next_pos;
   logic fifo_empty;
   logic set_underrun;
   logic wr_ctrl, wr_stat;

   fts_mode_t mode;
   logic pins_en, sof_fn, fbe_fn, clk_inv;
   logic inv_sof, inv_fbe, inv_pval, inv_pdat;
   logic [2:0] clk_sel;

   always_comb begin
      mode = fts_mode_t'(ctrl[FTS_CTRL_MODE_LSB +: 2]);
      pins_en = ctrl[FTS_CTRL_PINS_EN];
      sof_fn = ctrl[FTS_CTRL_SOF_FN];
      fbe_fn = ctrl[FTS_CTRL_FBE_FN];
      clk_sel = ctrl[FTS_CTRL_CSEL_LSB +: 3];
      clk_inv = ctrl[FTS_CTRL_CLK_INV];
      inv_sof = ctrl[FTS_CTRL_INV_SOF];
      inv_fbe = ctrl[FTS_CTRL_INV_FBE];
      inv_pval = ctrl[FTS_CTRL_INV_PVAL];
      inv_pdat = ctrl[FTS_CTRL_INV_PDAT];
   end

   always_comb begin
      // one wait state: ack in the cycle after the request is seen
      next_ack = wb_cyc_i && wb_stb_i && !ack;
      wr_ctrl = next_ack && wb_we_i && (wb_adr_i == FTS_REG_CTRL);
      wr_stat = next_ack && wb_we_i && (wb_adr_i == FTS_REG_STATUS);
      next_ctrl = ctrl;
      if (wr_ctrl && wb_sel_i[0]) begin
         next_ctrl[7:0] = wb_dat_i[7:0];
      end
      if (wr_ctrl && wb_sel_i[1]) begin
         next_ctrl[FTS_CTRL_W-1:8] = wb_dat_i[FTS_CTRL_W-1:8];
      end
      // write one clears; a fresh underrun in the same cycle wins
      next_underrun = underrun;
      if (wr_stat && wb_sel_i[1] && wb_dat_i[FTS_STAT_UNDERRUN]) begin
         next_underrun = 1'b0;
      end
      if (set_underrun) begin
         next_underrun = 1'b1;
      end
      next_rdata = 32'h0000_0000;
      if (next_ack && !wb_we_i) begin
         unique case (wb_adr_i)
            FTS_REG_CTRL: next_rdata[FTS_CTRL_W-1:0] = ctrl;
            FTS_REG_STATUS: begin
               next_rdata[FTS_STAT_POS_LSB +: POS_W] = pos;
               next_rdata[FTS_STAT_UNDERRUN] = underrun;
               next_rdata[FTS_STAT_FIFO_EMPTY] = fifo_empty;
            end
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= FTS_CTRL_RESET;
         underrun <= 1'b0;
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         underrun <= next_underrun;
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;

   // ---------------- reference choice guard ----------------
   // right after a new pin or edge is chosen the edge finder compares
   // samples of two different pins; that one cycle is masked
   logic [3:0] ref_choice, next_ref_choice;
   logic choice_held;

   always_comb begin
      next_ref_choice = {clk_inv, clk_sel};
      choice_held = (ref_choice == {clk_inv, clk_sel});
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_choice <= '0;
      end else begin
         ref_choice <= next_ref_choice;
      end
   end

   // ---------------- reference clock edge finder ----------------
   logic [FTS_NUM_CLKS-1:0] clk_meta, clk_sync;
   logic ref_prev, next_ref_prev, ref_now, tick;
   logic rise, fall;

   always_comb begin
      ref_now = (int'(clk_sel) < FTS_NUM_CLKS) ? clk_sync[clk_sel] : 1'b0;
      next_ref_prev = ref_now;
      rise = !ref_prev && ref_now;
      fall = ref_prev && !ref_now;
      // a change of choice may still cost one real edge, never adds one
      tick = choice_held && (clk_inv ? fall : rise);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_meta <= '0;
         clk_sync <= '0;
         ref_prev <= 1'b0;
      end else begin
         clk_meta <= {rx_line_clock_i, rx_clock_out_i, tx_clock_out_i,
                      tx_line_clock_i, tx_clock_in_i};
         clk_sync <= clk_meta;
         ref_prev <= next_ref_prev;
      end
   end

   // ---------------- frame position and strobes ----------------
   logic strobes_on, pay_on;
   logic sof, next_sof, fbe, next_fbe;
   logic fbe_level;

   always_comb begin
      strobes_on = pins_en && (mode != FTS_MODE_OFF);
      pay_on = pins_en && (mode == FTS_MODE_FLEX_FRAC);
      next_pos = pos;
      if (!strobes_on) begin
         next_pos = '0;
      end else if (tick) begin
         next_pos = (pos == POS_LAST) ? '0 : pos + 1'b1;
      end
      // position p means the bit at p is shown at this tick; strobes announce the bit lead ticks ahead
      fbe_level = (pos >= POS_FBE_RISE) && (pos < POS_FBE_FALL);
      next_sof = sof;
      next_fbe = fbe;
      if (!strobes_on) begin
         next_sof = inv_sof;
         next_fbe = inv_fbe;
      end else if (tick) begin
         next_sof = ((pos == POS_SOF) && sof_fn) ^ inv_sof;
         next_fbe = (fbe_level && fbe_fn) ^ inv_fbe;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos <= '0;
         sof <= 1'b0;
         fbe <= 1'b0;
      end else begin
         pos <= next_pos;
         sof <= next_sof;
         fbe <= next_fbe;
      end
   end

   assign tx_frame_start_pulse_o = sof;
   assign tx_frame_bit_enable_o = fbe;

   // ---------------- payload serialiser ----------------
   logic fifo_valid, fifo_ready;
   logic [WORD_W-1:0] fifo_data;
   logic [WORD_W-1:0] shreg, next_shreg;
   logic [CNT_W-1:0] bits_left, next_bits_left;
   logic pval, next_pval, pdat, next_pdat;
   logic pay_slot;

   fts_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) i_fts_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(pay_valid_i),
      .in_data_i(pay_data_i),
      .in_ready_o(pay_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(fifo_ready)
   );

   always_comb begin
      fifo_empty = !fifo_valid;
      pay_slot = pay_on && tick && (pos >= POS_PAY);
      // refill only between payload slots so a bit is never skipped
      fifo_ready = (bits_left == '0) && !pay_slot;
      next_shreg = shreg;
      next_bits_left = bits_left;
      next_pval = pval;
      next_pdat = pdat;
      set_underrun = 1'b0;
      if (fifo_ready && fifo_valid) begin
         next_shreg = fifo_data;
         next_bits_left = CNT_W'(WORD_W);
      end
      if (!pay_on) begin
         next_pval = inv_pval;
         next_pdat = inv_pdat;
      end else if (tick) begin
         next_pval = inv_pval;
         if (pay_slot && bits_left != '0) begin
            // msb first, valid marks exactly this bit period
            next_pval = !inv_pval;
            next_pdat = shreg[WORD_W-1] ^ inv_pdat;
            next_shreg = {shreg[WORD_W-2:0], 1'b0};
            next_bits_left = bits_left - 1'b1;
         end else if (pay_slot) begin
            set_underrun = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shreg <= '0;
         bits_left <= '0;
         pval <= 1'b0;
         pdat <= 1'b0;
      end else begin
         shreg <= next_shreg;
         bits_left <= next_bits_left;
         pval <= next_pval;
         pdat <= next_pdat;
      end
   end

   assign tx_payload_valid_out_o = pval;
   assign tx_payload_bit_out_o = pdat;
endmodule : fts_tx_strobes

// [sim/fts_far_end.sv]
// far-end logic model that gathers payload bits into words
`timescale 1ns/100ps
module fts_far_end (
   // reference clock and payload pins
   input wire logic ref_clk_i,
   input wire logic valid_i,
   input wire logic bit_i,
   // gathered words
   output logic [7:0] word_o,
   output logic word_stb_o
);
   logic [2:0] cnt = 3'h0;
   logic [7:0] sh = 8'h00;
   logic stb = 1'b0;
   // sampled at the reference edge, where the pins have long settled
   always @(posedge ref_clk_i) begin
      stb <= 1'b0;
      if (valid_i === 1'b1) begin
         sh <= {sh[6:0], bit_i};
         cnt <= cnt + 3'h1;
         stb <= cnt == 3'h7;
      end
   end
   assign word_o = sh;
   assign word_stb_o = stb;
endmodule : fts_far_end

// [sim/fts_tx_strobes_asserts.sv]
// assertions on the transmit frame strobe block ports
`timescale 1ns/100ps
module fts_tx_strobes_asserts
   import fts_pkg::*;
#(
   parameter int FRAME_BITS = 20,
   parameter int OH_BITS = 4
) (
   // clock, reset and bus
   input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [FTS_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i, wb_dat_o,
   // reference pins and strobes
   input wire logic tx_clock_in_i, tx_line_clock_i, tx_clock_out_i, rx_clock_out_i,
   input wire logic rx_line_clock_i, tx_frame_start_pulse_o, tx_frame_bit_enable_o,
   input wire logic tx_payload_valid_out_o, tx_payload_bit_out_o
);
   // counts assume a reference period of 8 clocks
   localparam int SOF_GAP = FRAME_BITS * 8;
   localparam int FBE_GAP = OH_BITS * 8;
   logic [12:0] ctl;
   logic [4:0] qc, pins;
   logic [5:0] hist;
   logic wr, quiet, en, sof_on, fbe_on, pv_on, pin, edge_ok, sof_a, fbe_a, pv_a, pd_a;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   assign pins = {rx_line_clock_i, rx_clock_out_i, tx_clock_out_i, tx_line_clock_i, tx_clock_in_i};
   assign wr = wb_ack_o && wb_we_i && wb_adr_i == FTS_REG_CTRL;
   assign pin = ctl[7:5] < 3'h5 ? pins[ctl[7:5]] : 1'b0;
   assign quiet = qc == 5'h1f;
   assign en = ctl[2] && ctl[1:0] != 2'h0;
   assign sof_on = en && ctl[3];
   assign fbe_on = en && ctl[4];
   assign pv_on = ctl[2] && ctl[1:0] == 2'h2;
   assign sof_a = tx_frame_start_pulse_o ^ ctl[9];
   assign fbe_a = tx_frame_bit_enable_o ^ ctl[10];
   assign pv_a = tx_payload_valid_out_o ^ ctl[11];
   assign pd_a = tx_payload_bit_out_o ^ ctl[12];
   // shadow control; settle counter hides the reconfiguration transient
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl <= FTS_CTRL_RESET;
         qc <= 5'h00;
         hist <= 6'h00;
      end else begin
         if (wr && wb_sel_i[0]) ctl[7:0] <= wb_dat_i[7:0];
         if (wr && wb_sel_i[1]) ctl[12:8] <= wb_dat_i[12:8];
         qc <= wr ? 5'h00 : qc + 5'(qc != 5'h1f);
         hist <= {hist[4:0], pin};
      end
   end
   // edge of the chosen direction one to four samples back
   always_comb begin
      edge_ok = 1'b0;
      for (int k = 1; k < 5; k++) edge_ok |= hist[k] != ctl[8] && hist[k+1] == ctl[8];
   end
   AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   AST_RDATA_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   AST_STROBE_EDGE: assert property (quiet && ctl[7:5] < 3'h5 && $changed({sof_a, fbe_a,
      pv_a, pd_a}) |-> edge_ok) else $error("strobe moved off the reference edge");
   AST_IDLE: assert property (quiet |-> (sof_on || !sof_a) && (fbe_on || !fbe_a)
      && (pv_on || !pv_a && !pd_a)) else $error("unused strobe not at rest level");
   AST_SOF_WIDTH: assert property (disable iff (rst_i || wr) quiet && $rose(sof_a)
      |-> sof_a[*8] ##1 !sof_a) else $error("frame start not one reference period");
   AST_SOF_PERIOD: assert property (disable iff (rst_i || wr) quiet && $rose(sof_a)
      |-> ##SOF_GAP $rose(sof_a)) else $error("frame start spacing wrong");
   AST_FBE_LEAD: assert property (disable iff (rst_i || wr) quiet && fbe_on && $rose(sof_a)
      |-> ##FBE_GAP $rose(fbe_a)) else $error("frame bit enable rise misplaced");
   AST_FBE_FALL: assert property (disable iff (rst_i || wr) quiet && sof_on && $fell(fbe_a)
      |-> $rose(sof_a)) else $error("frame bit enable fall misplaced");
   AST_PVAL_SPAN: assert property (quiet && fbe_on && pv_a |-> $past(fbe_a, 24))
      else $error("payload valid outside payload span");
endmodule : fts_tx_strobes_asserts
bind fts_tx_strobes fts_tx_strobes_asserts #(.FRAME_BITS(FRAME_BITS), .OH_BITS(OH_BITS))
   i_fts_tx_strobes_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .tx_clock_in_i(tx_clock_in_i), .tx_line_clock_i(tx_line_clock_i),
   .tx_clock_out_i(tx_clock_out_i), .rx_clock_out_i(rx_clock_out_i),
   .rx_line_clock_i(rx_line_clock_i), .tx_frame_start_pulse_o(tx_frame_start_pulse_o),
   .tx_frame_bit_enable_o(tx_frame_bit_enable_o),
   .tx_payload_valid_out_o(tx_payload_valid_out_o), .tx_payload_bit_out_o(tx_payload_bit_out_o));

// [sim/fts_tx_strobes_tb.sv]
// self-checking bench for the transmit frame strobe block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module fts_tx_strobes_tb;
   import fts_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, link_clk = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic pv = 1'b0, ack, prdy, sof, fbe, pvo, pbo, wstb, p;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rdat, lfsr = 32'h0000_229a;
   logic [7:0] pd = 8'h00, word;
   // no pin toggles until a clock is chosen, so the far end stays idle
   logic [2:0] src = 3'h7;
   logic [4:0] pins;
   logic [63:0] rq[$];
   logic [7:0] bq[$];
   int n_fail = 0, n_checks = 0, i, n, cnt;
   always #2 clk_i = ~clk_i;
   initial begin
      #1.3;
      forever #16 link_clk = ~link_clk;
   end
   // only the chosen pin toggles, so a wrong choice gives no frames
   assign pins = link_clk ? 5'(1 << src) : 5'h00;
   fts_tx_strobes #(.FRAME_BITS(20), .OH_BITS(4)) i_fts_tx_strobes (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .tx_clock_in_i(pins[0]), .tx_line_clock_i(pins[1]), .tx_clock_out_i(pins[2]),
      .rx_clock_out_i(pins[3]), .rx_line_clock_i(pins[4]), .pay_valid_i(pv), .pay_data_i(pd),
      .pay_ready_o(prdy), .tx_frame_start_pulse_o(sof), .tx_frame_bit_enable_o(fbe),
      .tx_payload_valid_out_o(pvo), .tx_payload_bit_out_o(pbo));
   fts_far_end i_fts_far_end (.ref_clk_i(pins[0]), .valid_i(pvo), .bit_i(pbo), .word_o(word),
      .word_stb_o(wstb));
   always @(posedge clk_i) if (ack && !we) begin
      `CHK("read data", rq[0][31:0], rdat & rq[0][63:32])
      void'(rq.pop_front());
   end
   always @(posedge link_clk) if (wstb) begin
      `CHK("payload word", bq[0], word)
      void'(bq.pop_front());
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task automatic report_and_stop;
      if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   // e holds mask and expected read data
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [63:0] e);
      int t;
      if (!w) rq.push_back(e);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (ack !== 1'b1 && t < 40);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         n_fail++;
         report_and_stop();
      end
      @(posedge clk_i);
   endtask : wb
   task automatic put(input logic [7:0] b);
      int t;
      pv <= 1'b1;
      pd <= b;
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (prdy !== 1'b1 && t < 20);
      pv <= 1'b0;
      if (prdy !== 1'b1) begin
         n_fail++;
         report_and_stop();
      end
      @(posedge clk_i);
   endtask : put
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, FTS_REG_CTRL, 0, {32'hffff_ffff, 32'h0000_0000});
      wb(0, FTS_REG_STATUS, 0, {32'hffff_ffff, 32'h0000_4000});
      wb(1, 4'h8, 32'hffff_ffff, 0);
      wb(0, 4'h8, 0, {32'hffff_ffff, 32'h0000_0000});
      // pins off: every strobe rests at its inverted level
      wb(1, FTS_REG_CTRL, 32'h0000_1e03, 0);
      repeat (40) @(posedge clk_i);
      `CHK("rest levels", 4'hf, {sof, fbe, pvo, pbo})
      wb(0, FTS_REG_CTRL, 0, {32'hffff_ffff, 32'h0000_1e03});
      for (i = 0; i < 5; i++) begin
         wb(1, FTS_REG_CTRL, 32'(i % 3 + 1) | 32'h1c | 32'(i) << 5 | 32'(i % 2) << 8
            | 32'(i / 2) << 9, 0);
         src <= 3'(i);
         cnt = 0;
         repeat (420) begin
            p = sof;
            @(posedge clk_i);
            cnt += int'(sof !== p);
         end
         `CHK("frame starts", 1'b1, cnt >= 4)
      end
      // fill with the serialiser off until refused, then drain in flexible mode
      wb(1, FTS_REG_CTRL, 0, 0);
      src <= 3'h0;
      n = 0;
      // offer only while ready stands, so a refusal is never a timeout
      while (prdy === 1'b1 && n < 40) begin
         lfsr = nxt(lfsr);
         put(lfsr[7:0]);
         bq.push_back(lfsr[7:0]);
         n++;
      end
      // the store holds FTS_FIFO_DEPTH words; its output stage and the idle shift register one each
      `CHK("words taken", FTS_FIFO_DEPTH + 2, n)
      wb(1, FTS_REG_CTRL, 32'h0000_001e, 0);
      for (i = 0; i < 8000 && bq.size() > 0; i++) @(posedge clk_i);
      `CHK("words left", 0, bq.size())
      repeat (400) @(posedge clk_i);
      wb(0, FTS_REG_STATUS, 0, {32'h0000_6000, 32'h0000_6000});
      wb(1, FTS_REG_CTRL, 0, 0);
      wb(1, FTS_REG_STATUS, 32'h0000_2000, 0);
      wb(0, FTS_REG_STATUS, 0, {32'h0000_2000, 32'h0000_0000});
      report_and_stop();
   end
endmodule : fts_tx_strobes_tb
